// [verilog/remap_pkg.sv]
// shared constants for the pin remap and routing lock block
package remap_pkg;
  localparam int ADDR_W        = 6;
  localparam int DATA_W        = 16;
  localparam int SEL_W         = 5;
  localparam int PIN_COUNT     = 16;
  localparam int IN_REG_COUNT  = 13;
  localparam int OUT_REG_COUNT = 8;
  localparam int PERIPH_IN_COUNT  = 6;
  localparam int PERIPH_OUT_COUNT = 8;

  // register word addresses
  localparam logic [ADDR_W-1:0] IN_ROUTE_BASE       = 6'h00;
  localparam logic [ADDR_W-1:0] OUT_ROUTE_BASE      = 6'h10;
  localparam logic [ADDR_W-1:0] OSC_CONTROL_ADDR    = 6'h20;
  localparam logic [ADDR_W-1:0] EXT_IRQ1_ROUTE_IDX  = 6'h00;
  localparam logic [ADDR_W-1:0] EXT_IRQ2_ROUTE_IDX  = 6'h01;
  localparam logic [ADDR_W-1:0] TIMER_CLK_ROUTE_IDX = 6'h03;
  localparam logic [ADDR_W-1:0] CAPTURE_ROUTE_IDX   = 6'h07;

  // field positions and implemented-bit masks
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam int LOCK_BIT     = 6;
  localparam logic [DATA_W-1:0] MASK_NONE = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_HI   = 16'h1F00;
  localparam logic [DATA_W-1:0] MASK_LO   = 16'h001F;
  localparam logic [DATA_W-1:0] MASK_BOTH = 16'h1F1F;

  // reset values
  localparam logic [DATA_W-1:0] ROUTE_RESET = 16'h0000;
  localparam logic              LOCK_RESET  = 1'b0;

  // unlock keys, written to the low byte of osc_control_reg
  localparam logic [7:0] KEY_FIRST  = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;

  // selection codes
  localparam logic [SEL_W-1:0] SEL_GROUND = 5'h1F;
  localparam logic [SEL_W-1:0] SEL_PIN_MAX = 5'h0F;
  localparam logic [SEL_W-1:0] OUT_NULL   = 5'h00;
  localparam logic [SEL_W-1:0] OUT_UART_TX  = 5'h03;
  localparam logic [SEL_W-1:0] OUT_UART_RTS = 5'h04;
  localparam logic [SEL_W-1:0] OUT_SPI_DO   = 5'h07;
  localparam logic [SEL_W-1:0] OUT_SPI_CLK  = 5'h08;
  localparam logic [SEL_W-1:0] OUT_SPI_SS   = 5'h09;
  localparam logic [SEL_W-1:0] OUT_CMP1     = 5'h12;
  localparam logic [SEL_W-1:0] OUT_CMP2     = 5'h13;
  localparam logic [SEL_W-1:0] OUT_QEI_DIR  = 5'h1A;

  // unlock sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_KEY1  = 3'b010,
    SEQ_ARMED = 3'b100
  } unlock_state_t;
endpackage

// [verilog/route_pick.sv]
// one input routing selector: sixteen pins or a tied-low level
`timescale 1ns/1ns
module route_pick (
  input  wire logic [remap_pkg::PIN_COUNT-1:0] pinLevel,
  input  wire logic [remap_pkg::PIN_COUNT-1:0] analogSel,
  input  wire logic [remap_pkg::SEL_W-1:0]     pinSel,
  output logic                                 pickOut
);
  import remap_pkg::*;

  logic [3:0] pinIdx;

  assign pinIdx = pinSel[3:0];

  always_comb begin
    pickOut = 1'b0;
    if (pinSel <= SEL_PIN_MAX) begin
      // analog pins stay analog; digital path sees low [RL10]
      pickOut = pinLevel[pinIdx] & ~analogSel[pinIdx]; // [RL7]
    end else if (pinSel == SEL_GROUND) begin
      pickOut = 1'b0; // [RL7]
    end else begin
      // unassigned codes behave as tied low
      pickOut = 1'b0;
    end
  end
endmodule

// [verilog/remap_input_select_lock.sv]
// peripheral pin remapping with key-protected routing lock
//
// Notes on behaviour
// [RL1] all input and output routing registers reset to zero
// [RL2] routing lock comes out of reset unlocked
// [RL3] software should lock routing after configuring it
// [RL4] software issues the key writes back to back, tightly
// [RL5] routing registers take writes only while unlocked
// [RL6] bank holds 13 input and 8 output routing registers
// [RL7] select codes 0 to 15 pick that pin; 31 ties the input low
// [RL8] routing leaves pin direction alone; mapped output reaches shared inputs
// [RL9] routing never enables a peripheral
// [RL10] routing never turns an analog pin digital
// [RL11] software parks unused inputs and gives spare pins the null output
// [RL12] external interrupt 1 select in bits 12-8, rest reads zero
// [RL13] external interrupt 2 select in bits 4-0, rest reads zero
// [RL14] timer 3 clock select bits 12-8, timer 2 clock select bits 4-0
// [RL15] capture 2 select bits 12-8, capture 1 select bits 4-0
// [RL16] lock changes only after keys 46h then 57h then one write
// [RL17] locked writes complete on the bus but change nothing
// [RL18] output code zero leaves the pin on its default port function
`timescale 1ns/1ns
module remap_input_select_lock (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst_n,
  input  wire logic [remap_pkg::ADDR_W-1:0]          regAddr,
  input  wire logic [remap_pkg::DATA_W-1:0]          regWrData,
  input  wire logic                                  regWr,
  input  wire logic                                  regRd,
  output logic      [remap_pkg::DATA_W-1:0]          regRdData,
  input  wire logic [remap_pkg::PIN_COUNT-1:0]       rpPinIn,
  input  wire logic [remap_pkg::PIN_COUNT-1:0]       analogSel,
  input  wire logic [remap_pkg::PIN_COUNT-1:0]       defaultPortOut,
  input  wire logic [remap_pkg::PIN_COUNT-1:0]       defaultPortOeN,
  input  wire logic                                  uartTx,
  input  wire logic                                  uartRts,
  input  wire logic                                  spiDataOut,
  input  wire logic                                  spiClkOut,
  input  wire logic                                  spiSelOut,
  input  wire logic                                  cmp1Out,
  input  wire logic                                  cmp2Out,
  input  wire logic                                  qeiDirOut,
  output logic      [remap_pkg::PIN_COUNT-1:0]       rpPinOut,
  output logic      [remap_pkg::PIN_COUNT-1:0]       rpPinOeN,
  output logic                                       extIrq1In,
  output logic                                       extIrq2In,
  output logic                                       tmr2ClkIn,
  output logic                                       tmr3ClkIn,
  output logic                                       cap1In,
  output logic                                       cap2In,
  output logic                                       routeLocked
);
  import remap_pkg::*;

  // register storage
  logic [DATA_W-1:0] inRoute_reg  [IN_REG_COUNT];
  logic [DATA_W-1:0] outRoute_reg [OUT_REG_COUNT];
  logic              lock_reg;
  unlock_state_t     seq_reg;
  unlock_state_t     seq_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;

  // pad synchroniser
  logic [PIN_COUNT-1:0] pinMeta_reg;
  logic [PIN_COUNT-1:0] pinSync_reg;

  // decode
  logic              oscWr;
  logic              inHit;
  logic              outHit;
  logic [ADDR_W-1:0] inIdx;
  logic [ADDR_W-1:0] outIdx;
  logic              routeWrEn;

  // routing paths
  logic [SEL_W-1:0]            periphSel  [PERIPH_IN_COUNT];
  logic [PERIPH_IN_COUNT-1:0]  periphPick;
  logic [PERIPH_IN_COUNT-1:0]  periphIn_reg;
  logic [PERIPH_OUT_COUNT-1:0] periphOutVec;
  logic [PIN_COUNT-1:0]        pinOut_next;
  logic [PIN_COUNT-1:0]        pinOut_reg;
  logic [PIN_COUNT-1:0]        pinOeN_reg;

  // implemented bits of each input routing slot; excluded slots read zero
  function automatic logic [DATA_W-1:0] inMask(input logic [ADDR_W-1:0] idx);
    logic [DATA_W-1:0] m;
    m = MASK_NONE;
    if (idx == EXT_IRQ1_ROUTE_IDX) begin
      m = MASK_HI; // [RL12]
    end else if (idx == EXT_IRQ2_ROUTE_IDX) begin
      m = MASK_LO; // [RL13]
    end else if (idx == TIMER_CLK_ROUTE_IDX) begin
      m = MASK_BOTH; // [RL14]
    end else if (idx == CAPTURE_ROUTE_IDX) begin
      m = MASK_BOTH; // [RL15]
    end
    return m;
  endfunction

  // peripheral output chosen by a pin's output selection code
  function automatic logic [1:0] outPick(input logic [SEL_W-1:0] code,
                                         input logic [PERIPH_OUT_COUNT-1:0] vec);
    logic [1:0] r;
    r = 2'b00;
    case (code)
      OUT_UART_TX:  r = {1'b1, vec[0]};
      OUT_UART_RTS: r = {1'b1, vec[1]};
      OUT_SPI_DO:   r = {1'b1, vec[2]};
      OUT_SPI_CLK:  r = {1'b1, vec[3]};
      OUT_SPI_SS:   r = {1'b1, vec[4]};
      OUT_CMP1:     r = {1'b1, vec[5]};
      OUT_CMP2:     r = {1'b1, vec[6]};
      OUT_QEI_DIR:  r = {1'b1, vec[7]};
      default:      r = 2'b00;
    endcase
    return r;
  endfunction

  // address decode
  assign inIdx  = regAddr - IN_ROUTE_BASE;
  assign outIdx = regAddr - OUT_ROUTE_BASE;

  always_comb begin
    oscWr  = 1'b0;
    inHit  = 1'b0;
    outHit = 1'b0;
    if (regAddr == OSC_CONTROL_ADDR) begin
      oscWr = regWr;
    end else if (regAddr >= IN_ROUTE_BASE &&
                 regAddr < IN_ROUTE_BASE + ADDR_W'(IN_REG_COUNT)) begin
      inHit = 1'b1; // [RL6]
    end else if (regAddr >= OUT_ROUTE_BASE &&
                 regAddr < OUT_ROUTE_BASE + ADDR_W'(OUT_REG_COUNT)) begin
      outHit = 1'b1; // [RL6]
    end
  end

  // locked writes are accepted on the bus but dropped here
  assign routeWrEn = regWr & ~lock_reg; // [RL5] [RL17]

  // input routing registers
  generate
    for (genvar i = 0; i < IN_REG_COUNT; i++) begin : g_inRoute
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          inRoute_reg[i] <= ROUTE_RESET; // [RL1]
        end else if (routeWrEn && inHit && inIdx == ADDR_W'(i)) begin
          inRoute_reg[i] <= regWrData & inMask(ADDR_W'(i)); // [RL5]
        end
      end
    end
  endgenerate

  // output routing registers, two pins per register
  generate
    for (genvar j = 0; j < OUT_REG_COUNT; j++) begin : g_outRoute
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          outRoute_reg[j] <= ROUTE_RESET; // [RL1]
        end else if (routeWrEn && outHit && outIdx == ADDR_W'(j)) begin
          outRoute_reg[j] <= regWrData & MASK_BOTH; // [RL5]
        end
      end
    end
  endgenerate

  // unlock sequencer: keys must land on consecutive cycles, since any
  // gap would let stray code slip between them
  always_comb begin
    seq_next = SEQ_IDLE;
    case (seq_reg)
      SEQ_IDLE: begin
        if (oscWr && regWrData[7:0] == KEY_FIRST) begin
          seq_next = SEQ_KEY1; // [RL16]
        end
      end
      SEQ_KEY1: begin
        if (oscWr && regWrData[7:0] == KEY_SECOND) begin
          seq_next = SEQ_ARMED; // [RL16] [RL4]
        end else if (oscWr && regWrData[7:0] == KEY_FIRST) begin
          seq_next = SEQ_KEY1;
        end
      end
      SEQ_ARMED: begin
        seq_next = SEQ_IDLE;
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // lock bit: only the write right after both keys touches it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= LOCK_RESET; // [RL2]
    end else if (seq_reg == SEQ_ARMED && oscWr) begin
      lock_reg <= regWrData[LOCK_BIT]; // [RL16]
    end
  end

  assign routeLocked = lock_reg;

  // read data, valid the cycle after the strobe only
  always_comb begin
    rdData_next = '0;
    if (regRd) begin
      if (regAddr == OSC_CONTROL_ADDR) begin
        rdData_next[LOCK_BIT] = lock_reg;
      end else if (inHit) begin
        rdData_next = inRoute_reg[inIdx[3:0]] & inMask(inIdx); // [RL12] [RL13]
      end else if (outHit) begin
        rdData_next = outRoute_reg[outIdx[2:0]];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // pads come from outside the clock domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else begin
      pinMeta_reg <= rpPinIn;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // selection fields of the routed peripheral inputs
  assign periphSel[0] = inRoute_reg[EXT_IRQ1_ROUTE_IDX[3:0]][HI_FIELD_LSB +: SEL_W];  // [RL12]
  assign periphSel[1] = inRoute_reg[EXT_IRQ2_ROUTE_IDX[3:0]][LO_FIELD_LSB +: SEL_W];  // [RL13]
  assign periphSel[2] = inRoute_reg[TIMER_CLK_ROUTE_IDX[3:0]][LO_FIELD_LSB +: SEL_W]; // [RL14]
  assign periphSel[3] = inRoute_reg[TIMER_CLK_ROUTE_IDX[3:0]][HI_FIELD_LSB +: SEL_W]; // [RL14]
  assign periphSel[4] = inRoute_reg[CAPTURE_ROUTE_IDX[3:0]][LO_FIELD_LSB +: SEL_W];   // [RL15]
  assign periphSel[5] = inRoute_reg[CAPTURE_ROUTE_IDX[3:0]][HI_FIELD_LSB +: SEL_W];   // [RL15]

  generate
    for (genvar k = 0; k < PERIPH_IN_COUNT; k++) begin : g_pick
      route_pick u_pick (
        .pinLevel  (pinSync_reg),
        .analogSel (analogSel),
        .pinSel    (periphSel[k]),
        .pickOut   (periphPick[k])
      );
    end
  endgenerate

  // routed levels only; no enable ever goes to the peripherals [RL9]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periphIn_reg <= '0;
    end else begin
      periphIn_reg <= periphPick; // [RL7]
    end
  end

  assign extIrq1In = periphIn_reg[0];
  assign extIrq2In = periphIn_reg[1];
  assign tmr2ClkIn = periphIn_reg[2];
  assign tmr3ClkIn = periphIn_reg[3];
  assign cap1In    = periphIn_reg[4];
  assign cap2In    = periphIn_reg[5];

  assign periphOutVec = {qeiDirOut, cmp2Out, cmp1Out, spiSelOut,
                         spiClkOut, spiDataOut, uartRts, uartTx};

  // output side: the port keeps its own direction; only the driven level
  // is swapped, so a mapped output also loops back into shared inputs
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pinOut
      logic [SEL_W-1:0] code;
      logic [1:0]       pick;
      assign code = outRoute_reg[p / 2][((p % 2) * HI_FIELD_LSB) +: SEL_W];
      assign pick = outPick(code, periphOutVec);
      // null and unassigned codes fall back to the default port level
      assign pinOut_next[p] = pick[1] ? pick[0] : defaultPortOut[p]; // [RL18] [RL8]
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_reg <= '0;
      pinOeN_reg <= '1;
    end else begin
      pinOut_reg <= pinOut_next;
      // direction and analog state come straight from the port [RL8] [RL10]
      pinOeN_reg <= defaultPortOeN;
    end
  end

  assign rpPinOut = pinOut_reg;
  assign rpPinOeN = pinOeN_reg;
endmodule

// [verification/remap_input_select_lock_properties.sv]
// port-level assertions for the pin remap and routing lock block
`timescale 1ns/1ns
module remap_lock_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic [15:0] analogSel,
  input wire logic [15:0] defaultPortOeN,
  input wire logic [15:0] rpPinOeN,
  input wire logic        extIrq1In,
  input wire logic        extIrq2In,
  input wire logic        tmr2ClkIn,
  input wire logic        tmr3ClkIn,
  input wire logic        cap1In,
  input wire logic        cap2In,
  input wire logic        routeLocked
);
  import remap_pkg::*;
  logic oscWr;
  logic keyA;
  logic keyB;
  logic anyIn;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  assign oscWr = regWr && (regAddr == OSC_CONTROL_ADDR);
  assign keyA = oscWr && (regWrData[7:0] == KEY_FIRST);
  assign keyB = oscWr && (regWrData[7:0] == KEY_SECOND);
  assign anyIn = extIrq1In | extIrq2In | tmr2ClkIn | tmr3ClkIn | cap1In | cap2In;
  property spare_zero(idx, mask);
    regRd && regAddr == idx |=> (regRdData & ~mask) == 16'h0000;
  endproperty
  chk_irq1_spare: assert property (spare_zero(EXT_IRQ1_ROUTE_IDX, MASK_HI))
    else $error("irq1 route spare bits not zero");
  chk_irq2_spare: assert property (spare_zero(EXT_IRQ2_ROUTE_IDX, MASK_LO))
    else $error("irq2 route spare bits not zero");
  chk_timer_spare: assert property (spare_zero(TIMER_CLK_ROUTE_IDX, MASK_BOTH))
    else $error("timer route spare bits not zero");
  chk_capture_spare: assert property (spare_zero(CAPTURE_ROUTE_IDX, MASK_BOTH))
    else $error("capture route spare bits not zero");
  chk_lock_only_keys: assert property (
    !$stable(routeLocked) |-> $past(oscWr) && $past(keyB, 2) && $past(keyA, 3))
    else $error("lock changed without the key sequence");
  // third write kept off key values so it cannot be taken for a new start
  chk_lock_takes_bit: assert property (
    keyA ##1 keyB ##1 (oscWr && !keyA && !keyB) |=> routeLocked == $past(regWrData[LOCK_BIT]))
    else $error("lock did not follow the third write");
  chk_lock_readback: assert property (
    regRd && regAddr == OSC_CONTROL_ADDR |=> regRdData == {9'h000, $past(routeLocked), 6'h00})
    else $error("lock readback wrong");
  chk_oe_untouched: assert property (1'b1 |=> rpPinOeN == $past(defaultPortOeN))
    else $error("pin enable altered by routing");
  // margin of five cycles covers the output flop; analogSel bypasses the synchroniser
  chk_analog_quiet: assert property (analogSel == 16'hFFFF [*5] |-> !anyIn)
    else $error("analog pin reached a routed input");
  cover property (keyA ##1 keyB ##1 oscWr);
  cover property (routeLocked && regWr && regAddr == EXT_IRQ1_ROUTE_IDX);
  cover property (regRd && regAddr == CAPTURE_ROUTE_IDX);
endmodule

// [verification/test_remap_input_select_lock.sv]
// self-checking bench for the pin remap and routing lock block
`timescale 1ns/1ns
module test_remap_input_select_lock;
  import remap_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdData;
  logic [15:0] rpPinIn = 16'h0000;
  logic [15:0] analogSel = 16'h0000;
  logic [15:0] defaultPortOut = 16'h5555;
  logic [15:0] defaultPortOeN = 16'h3C5A;
  logic [7:0]  periph = 8'h00;
  logic [15:0] rpPinOut;
  logic [15:0] rpPinOeN;
  wire  [5:0]  routed;
  logic        routeLocked;
  int          nMismatch = 0;
  int          checkCount = 0;
  logic [5:0]  inIdx [4] = '{6'h00, 6'h01, 6'h03, 6'h07};
  logic [15:0] inMask [4] = '{16'h1F00, 16'h001F, 16'h1F1F, 16'h1F1F};
  logic [4:0]  pinCode [5] = '{5'h10, 5'h1F, 5'h00, 5'h0F, 5'h05};
  logic [4:0]  outCode [8] = '{OUT_UART_TX, OUT_UART_RTS, OUT_SPI_DO, OUT_SPI_CLK,
                               OUT_SPI_SS, OUT_CMP1, OUT_CMP2, OUT_QEI_DIR};

  always #20 ref_clk = ~ref_clk;

  remap_input_select_lock u_remap_input_select_lock (
    .ref_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .rpPinIn, .analogSel, .defaultPortOut, .defaultPortOeN,
    .uartTx(periph[0]), .uartRts(periph[1]), .spiDataOut(periph[2]),
    .spiClkOut(periph[3]), .spiSelOut(periph[4]), .cmp1Out(periph[5]),
    .cmp2Out(periph[6]), .qeiDirOut(periph[7]), .rpPinOut, .rpPinOeN,
    .extIrq1In(routed[0]), .extIrq2In(routed[1]), .tmr2ClkIn(routed[2]),
    .tmr3ClkIn(routed[3]), .cap1In(routed[4]), .cap2In(routed[5]), .routeLocked
  );

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobe left high so back-to-back writes land on consecutive edges
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regRd <= 1'b0;
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
  endtask

  task idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
    end
  endtask

  task rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    check("read data", regRdData, e);
  endtask

  task lockSeq(input logic v, input logic expLock);
    wr(OSC_CONTROL_ADDR, 16'h0046);
    wr(OSC_CONTROL_ADDR, 16'h0057);
    wr(OSC_CONTROL_ADDR, {9'h000, v, 6'h00});
    idle(1);
    @(negedge ref_clk);
    check("lock", {15'h0000, routeLocked}, {15'h0000, expLock});
  endtask

  task endOfTest;
    $display("mismatches %0d checks %0d", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    endOfTest();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    check("pin enable in reset", rpPinOeN, 16'hFFFF);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(inIdx[i], ROUTE_RESET);
    rd(OUT_ROUTE_BASE, ROUTE_RESET);
    rd(OSC_CONTROL_ADDR, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(inIdx[i], 16'hFFFF);
      rd(inIdx[i], inMask[i]);
    end
    wr(6'h02, 16'hFFFF);
    rd(6'h02, 16'h0000);
    rd(6'h3F, 16'h0000);
    // each code on every routed input, first with only that pin high (all pins high for codes 10h and 1Fh)
    foreach (pinCode[c]) begin
      for (int i = 0; i < 4; i++) wr(inIdx[i], {3'b000, pinCode[c], 3'b000, pinCode[c]});
      idle(1);
      rpPinIn <= pinCode[c][4] ? 16'hFFFF : 16'h0001 << pinCode[c];
      idle(6);
      check("routed high", {10'h000, routed}, pinCode[c][4] ? 16'h0000 : 16'h003F);
      rpPinIn <= ~(16'h0001 << pinCode[c][3:0]);
      idle(6);
      check("routed low", {10'h000, routed}, 16'h0000);
    end
    rpPinIn <= 16'hFFFF;
    analogSel <= 16'h0020;
    idle(6);
    check("analog pin", {10'h000, routed}, 16'h0000);
    analogSel <= 16'h0000;
    idle(6);
    check("digital pin", {10'h000, routed}, 16'h003F);
    // every pin analog long enough to reach the checker's window
    analogSel <= 16'hFFFF;
    idle(8);
    check("all analog", {10'h000, routed}, 16'h0000);
    analogSel <= 16'h0000;
    foreach (outCode[i]) begin
      wr(OUT_ROUTE_BASE, {3'b000, outCode[i], 8'h00});
      idle(1);
      periph <= 8'h01 << i;
      idle(3);
      check("mapped out high", rpPinOut, 16'h5557);
      periph <= ~(8'h01 << i);
      idle(3);
      check("mapped out low", rpPinOut, 16'h5555);
      check("pin enable", rpPinOeN, 16'h3C5A);
    end
    lockSeq(1'b1, 1'b1);
    wr(EXT_IRQ1_ROUTE_IDX, 16'h0A00);
    wr(OUT_ROUTE_BASE, 16'h0000);
    rd(EXT_IRQ1_ROUTE_IDX, 16'h0500);
    rd(OUT_ROUTE_BASE, 16'h1A00);
    rd(OSC_CONTROL_ADDR, 16'h0040);
    wr(OSC_CONTROL_ADDR, 16'h0046);
    idle(1);
    wr(OSC_CONTROL_ADDR, 16'h0057);
    wr(OSC_CONTROL_ADDR, 16'h0000);
    idle(2);
    check("lock after gap", {15'h0000, routeLocked}, 16'h0001);
    lockSeq(1'b0, 1'b0);
    wr(EXT_IRQ1_ROUTE_IDX, 16'h0A00);
    rd(EXT_IRQ1_ROUTE_IDX, 16'h0A00);
    // spare pin gets the null code; peripherals high must not reach it
    wr(OUT_ROUTE_BASE, 16'h0000);
    idle(1);
    periph <= 8'hFF;
    idle(3);
    check("null code", rpPinOut, 16'h5555);
    lockSeq(1'b1, 1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(EXT_IRQ1_ROUTE_IDX, ROUTE_RESET);
    rd(OSC_CONTROL_ADDR, 16'h0000);
    endOfTest();
  end
endmodule

bind remap_input_select_lock remap_lock_checker u_remap_lock_checker (
  .ref_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .analogSel,
  .defaultPortOeN, .rpPinOeN, .extIrq1In, .extIrq2In, .tmr2ClkIn, .tmr3ClkIn,
  .cap1In, .cap2In, .routeLocked
);
